/* src/cdf_pkg.sv */
// Package of constants and types for the coil driver fault control block
package cdf_pkg;
    // Number of coil channels
    localparam int unsigned NUM_COILS = 6;
    // Number of coil current steps
    localparam int unsigned NUM_STEPS = 20;
    // Width of the current step selector
    localparam int unsigned STEP_W = 5;
    // Highest legal step index
    localparam logic [4:0] STEP_MAX = 5'h13;
    // Reset value of the current step (lowest current)
    localparam logic [4:0] STEP_RST = 5'h00;
    // Width of the coil select index
    localparam int unsigned SEL_W = 3;
    // Reset value of the coil select index
    localparam logic [2:0] SEL_RST = 3'h0;
    // Fault cause bit positions in the fault record
    localparam int unsigned FLT_POS_BAT = 0;
    localparam int unsigned FLT_POS_GND = 1;
    localparam int unsigned FLT_POS_OPEN = 2;
    localparam int unsigned FLT_POS_TEMP = 3;
    // Fault record width and reset value
    localparam int unsigned FLT_W = 4;
    localparam logic [3:0] FLT_RST = 4'h0;
    // Core clock rate and boost switching rate, in Hz
    localparam longint unsigned CLK_HZ = 125000000;
    localparam longint unsigned BOOST_HZ = 125000;
    // Oscillator rate that the boost rate is quoted for, in Hz
    localparam longint unsigned OSC_REF_HZ = 8000000;
    // Fixed divider, the ratio of oscillator to switching rate
    localparam int unsigned BOOST_DIV = int'(OSC_REF_HZ / BOOST_HZ);
    // Width of the boost divider counter
    localparam int unsigned BOOST_CNT_W = 10;
    // Default carrier period in clock cycles
    localparam int unsigned CARRIER_CYC = 1000;
    // Width of the carrier phase counter
    localparam int unsigned PHASE_W = 12;
    // Operating modes of the block
    typedef enum logic [2:0] {
        CDF_POWER_DOWN,
        CDF_IDLE,
        CDF_TRANSMIT,
        CDF_SHUTDOWN,
        CDF_DIAGNOSIS
    } cdf_mode_t;
endpackage

/* src/cdf_boost_ctrl.sv */
// Boost converter enable, overload cut-off and switching clock divider
`timescale 1ns/10ps
`default_nettype none
module cdf_boost_ctrl #(
    parameter int unsigned DIV = cdf_pkg::BOOST_DIV
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic transmit_i,
    input wire logic switch_overcurrent_i,
    input wire logic supply_overvoltage_i,
    output logic boost_enable_o,
    output logic boost_switch_clk_o
);
    // Divider counter and half-period flag
    logic [cdf_pkg::BOOST_CNT_W-1:0] div_cnt_ff;
    logic sw_clk_ff;
    logic enable_ff;
    // Half period of the switching clock
    localparam logic [cdf_pkg::BOOST_CNT_W-1:0] HALF =
        cdf_pkg::BOOST_CNT_W'(DIV / 2 - 1);

    // ****************************************************************
    // Enable, only while transmitting
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            enable_ff <= 1'b0;
        end else begin
            enable_ff <= transmit_i;
        end
    end

    // ****************************************************************
    // Switching clock by fixed division, stopped on overload
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            div_cnt_ff <= '0;
            sw_clk_ff <= 1'b0;
        end else if (!transmit_i || switch_overcurrent_i || supply_overvoltage_i) begin
            // Held low while disabled or over limit
            div_cnt_ff <= '0;
            sw_clk_ff <= 1'b0;
        end else if (div_cnt_ff == HALF) begin
            // Half period done, toggle
            div_cnt_ff <= '0;
            sw_clk_ff <= ~sw_clk_ff;
        end else begin
            div_cnt_ff <= div_cnt_ff + 1'b1;
        end
    end

    assign boost_enable_o = enable_ff;
    assign boost_switch_clk_o = sw_clk_ff;
endmodule
`default_nettype wire

/* src/cdf_core.sv */
// Top of the coil driver fault control block: modes, line states, faults
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Any fault tri-states all six driver stages
// - Fault shutdown disconnects shunt from return lines
// - Fault shutdown records its cause
// - Every fault shutdown raises the interrupt request
// - Causes: line shorts, open load, overtemperature
// - Line monitoring runs in idle and transmit, unrequested
// - Fault clear returns to idle; transmission needs a new start
// - Diagnosis tri-states drivers, keeps test structures
// - Twenty current steps selectable by the host
// - Out-of-group steps applied, not rejected
// - Boost enabled only during transmission
// - Boost stops on overcurrent or overvoltage
// - Boost clock is core clock divided by 64, fixed
// - Sample shunt a quarter period after crossing
// - Idle presets integrator to battery level
// - Unselected coils tied to driver supply
// - Shutdown left by fault clear or reset
module cdf_core #(
    parameter int unsigned CARRIER = cdf_pkg::CARRIER_CYC
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic wake_i,
    input wire logic power_down_req_i,
    input wire logic transmit_start_i,
    input wire logic transmit_stop_i,
    input wire logic diag_enter_i,
    input wire logic fault_clear_i,
    input wire logic [2:0] coil_select_i,
    input wire logic select_load_i,
    input wire logic [4:0] step_i,
    input wire logic step_load_i,
    input wire logic [5:0] short_bat_i,
    input wire logic [5:0] short_gnd_i,
    input wire logic [5:0] open_load_i,
    input wire logic over_temp_i,
    input wire logic zero_cross_i,
    input wire logic switch_overcurrent_i,
    input wire logic supply_overvoltage_i,
    output logic [2:0] mode_o,
    output logic [5:0] coil_positive_line_drive_o,
    output logic [5:0] coil_positive_line_active_o,
    output logic [5:0] coil_positive_line_mid_o,
    output logic [5:0] coil_return_line_drive_o,
    output logic [5:0] coil_return_line_high_o,
    output logic shunt_connect_o,
    output logic diag_test_enable_o,
    output logic [3:0] fault_cause_o,
    output logic [5:0] fault_coil_o,
    output logic irq_o,
    output logic [4:0] current_step_o,
    output logic [2:0] coil_select_o,
    output logic integrator_preset_o,
    output logic shunt_sample_o,
    output logic boost_enable_o,
    output logic boost_switch_clk_o
);
    // Quarter carrier period in clock cycles
    localparam logic [cdf_pkg::PHASE_W-1:0] QUARTER =
        cdf_pkg::PHASE_W'(CARRIER / 4);

    // Mode state, fault record, interrupt and settings
    cdf_pkg::cdf_mode_t mode_ff;
    cdf_pkg::cdf_mode_t nxt_mode;
    logic [cdf_pkg::FLT_W-1:0] fault_ff;
    logic [5:0] fault_coil_ff;
    logic irq_ff;
    logic [4:0] step_ff;
    logic [2:0] sel_ff;
    logic [cdf_pkg::PHASE_W-1:0] phase_ff;
    logic phase_run_ff;
    logic sample_ff;
    // Combined fault detection
    logic fault_now;
    logic [cdf_pkg::FLT_W-1:0] cause_now;
    logic [5:0] coil_now;
    logic running;

    // One-hot decode of a coil index
    function automatic logic [5:0] coil_onehot(input logic [2:0] idx);
        logic [5:0] v;
        v = '0;
        if (idx < 3'(cdf_pkg::NUM_COILS)) begin
            v[idx] = 1'b1;
        end
        return v;
    endfunction

    // ****************************************************************
    // Fault detection
    // ****************************************************************
    // Monitoring runs in idle and transmit with no request needed
    assign running = (mode_ff == cdf_pkg::CDF_IDLE) || (mode_ff == cdf_pkg::CDF_TRANSMIT);
    always_comb begin
        cause_now = '0;
        cause_now[cdf_pkg::FLT_POS_BAT] = |short_bat_i;
        cause_now[cdf_pkg::FLT_POS_GND] = |short_gnd_i;
        cause_now[cdf_pkg::FLT_POS_OPEN] = |open_load_i;
        cause_now[cdf_pkg::FLT_POS_TEMP] = over_temp_i;
        coil_now = short_bat_i | short_gnd_i | open_load_i;
        fault_now = running && (|cause_now);
    end

    // ****************************************************************
    // Mode sequencing
    // ****************************************************************
    always_comb begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            cdf_pkg::CDF_POWER_DOWN: begin
                // Woken by chip select high
                if (wake_i) begin
                    nxt_mode = cdf_pkg::CDF_IDLE;
                end
            end
            cdf_pkg::CDF_IDLE: begin
                if (fault_now) begin
                    nxt_mode = cdf_pkg::CDF_SHUTDOWN;
                end else if (power_down_req_i) begin
                    nxt_mode = cdf_pkg::CDF_POWER_DOWN;
                end else if (diag_enter_i) begin
                    nxt_mode = cdf_pkg::CDF_DIAGNOSIS;
                end else if (transmit_start_i) begin
                    nxt_mode = cdf_pkg::CDF_TRANSMIT;
                end
            end
            cdf_pkg::CDF_TRANSMIT: begin
                if (fault_now) begin
                    nxt_mode = cdf_pkg::CDF_SHUTDOWN;
                end else if (transmit_stop_i) begin
                    nxt_mode = cdf_pkg::CDF_IDLE;
                end
            end
            cdf_pkg::CDF_SHUTDOWN: begin
                // Only fault clear leaves, besides reset
                if (fault_clear_i) begin
                    nxt_mode = cdf_pkg::CDF_IDLE;
                end
            end
            cdf_pkg::CDF_DIAGNOSIS: begin
                // Left by the fault clear command
                if (fault_clear_i) begin
                    nxt_mode = cdf_pkg::CDF_IDLE;
                end
            end
            default: begin
                nxt_mode = cdf_pkg::CDF_POWER_DOWN;
            end
        endcase
    end

    // Mode register
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            mode_ff <= cdf_pkg::CDF_POWER_DOWN;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ****************************************************************
    // Fault record and interrupt
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            fault_ff <= cdf_pkg::FLT_RST;
            fault_coil_ff <= '0;
        end else if (fault_now) begin
            // Capture wins over a clear in the same cycle
            fault_ff <= fault_ff | cause_now;
            fault_coil_ff <= fault_coil_ff | coil_now;
        end else if (fault_clear_i) begin
            fault_ff <= cdf_pkg::FLT_RST;
            fault_coil_ff <= '0;
        end
    end

    // Interrupt request, set by each shutdown and dropped by clear
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            irq_ff <= 1'b0;
        end else if (fault_now) begin
            irq_ff <= 1'b1;
        end else if (fault_clear_i) begin
            irq_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // Host settings: coil select and current step
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sel_ff <= cdf_pkg::SEL_RST;
        end else if (select_load_i && (coil_select_i < 3'(cdf_pkg::NUM_COILS))) begin
            sel_ff <= coil_select_i;
        end
    end

    // Any of the twenty steps accepted whatever the coil group
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            step_ff <= cdf_pkg::STEP_RST;
        end else if (step_load_i && (step_i <= cdf_pkg::STEP_MAX)) begin
            step_ff <= step_i;
        end
    end

    // ****************************************************************
    // Peak sampling a quarter period after each zero crossing
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || mode_ff != cdf_pkg::CDF_TRANSMIT) begin
            phase_ff <= '0;
            phase_run_ff <= 1'b0;
            sample_ff <= 1'b0;
        end else if (zero_cross_i) begin
            // Restart the count at each crossing
            phase_ff <= '0;
            phase_run_ff <= 1'b1;
            sample_ff <= 1'b0;
        end else if (phase_run_ff && phase_ff == QUARTER - 1'b1) begin
            phase_ff <= '0;
            phase_run_ff <= 1'b0;
            sample_ff <= 1'b1;
        end else begin
            phase_ff <= phase_run_ff ? phase_ff + 1'b1 : phase_ff;
            sample_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // Boost converter control
    // ****************************************************************
    cdf_boost_ctrl #(
        .DIV(cdf_pkg::BOOST_DIV)
    ) u_boost (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .transmit_i(mode_ff == cdf_pkg::CDF_TRANSMIT),
        .switch_overcurrent_i(switch_overcurrent_i),
        .supply_overvoltage_i(supply_overvoltage_i),
        .boost_enable_o(boost_enable_o),
        .boost_switch_clk_o(boost_switch_clk_o)
    );

    // ****************************************************************
    // Line states per mode
    // ****************************************************************
    always_comb begin
        logic [5:0] sel_hot;
        sel_hot = coil_onehot(sel_ff);
        coil_positive_line_drive_o = '0;
        coil_positive_line_active_o = '0;
        coil_positive_line_mid_o = '0;
        coil_return_line_drive_o = '0;
        coil_return_line_high_o = '0;
        unique case (mode_ff)
            cdf_pkg::CDF_IDLE: begin
                // Selected positive mid-supply, others to supply level
                coil_positive_line_drive_o = 6'h3f;
                coil_positive_line_mid_o = sel_hot;
                coil_return_line_drive_o = 6'h3f;
                coil_return_line_high_o = ~sel_hot;
            end
            cdf_pkg::CDF_TRANSMIT: begin
                // Selected driver runs, others at supply level
                coil_positive_line_drive_o = 6'h3f;
                coil_positive_line_active_o = sel_hot;
                coil_return_line_drive_o = 6'h3f;
                coil_return_line_high_o = ~sel_hot;
            end
            default: begin
                // Power-down, shutdown and diagnosis leave all lines open
                coil_positive_line_drive_o = '0;
                coil_return_line_drive_o = '0;
            end
        endcase
    end

    assign mode_o = mode_ff;
    assign shunt_connect_o = (mode_ff == cdf_pkg::CDF_IDLE) || (mode_ff == cdf_pkg::CDF_TRANSMIT);
    assign diag_test_enable_o = (mode_ff == cdf_pkg::CDF_DIAGNOSIS);
    assign integrator_preset_o = (mode_ff == cdf_pkg::CDF_IDLE);
    assign fault_cause_o = fault_ff;
    assign fault_coil_o = fault_coil_ff;
    assign irq_o = irq_ff;
    assign current_step_o = step_ff;
    assign coil_select_o = sel_ff;
    assign shunt_sample_o = sample_ff;
endmodule
`default_nettype wire

/* tb/cdf_core_checker.sv */
// Concurrent checks on the ports of the coil driver fault control top
`timescale 1ns/10ps
`default_nettype none
module cdf_core_checker #(
    parameter int unsigned CARRIER = 1000
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic fault_clear_i,
    input wire logic [4:0] step_i,
    input wire logic step_load_i,
    input wire logic [5:0] short_bat_i,
    input wire logic [5:0] short_gnd_i,
    input wire logic [5:0] open_load_i,
    input wire logic over_temp_i,
    input wire logic zero_cross_i,
    input wire logic switch_overcurrent_i,
    input wire logic supply_overvoltage_i,
    input wire logic [2:0] mode_o,
    input wire logic [5:0] coil_positive_line_drive_o,
    input wire logic [5:0] coil_positive_line_mid_o,
    input wire logic [5:0] coil_return_line_drive_o,
    input wire logic [5:0] coil_return_line_high_o,
    input wire logic shunt_connect_o,
    input wire logic diag_test_enable_o,
    input wire logic [3:0] fault_cause_o,
    input wire logic irq_o,
    input wire logic [4:0] current_step_o,
    input wire logic [2:0] coil_select_o,
    input wire logic integrator_preset_o,
    input wire logic shunt_sample_o,
    input wire logic boost_enable_o,
    input wire logic boost_switch_clk_o
);
    // ****************************************
    // Helper logic
    // ****************************************
    logic [3:0] cause; // Fault causes seen at the inputs
    logic run; // Idle or transmit
    logic [5:0] sel1h; // Selected coil, one-hot
    logic [11:0] qcnt_ff; // Cycles since the last crossing
    assign cause = {over_temp_i, |open_load_i, |short_gnd_i, |short_bat_i};
    assign run = (mode_o == 3'h1) || (mode_o == 3'h2);
    assign sel1h = 6'h01 << coil_select_o;
    // Counts from each zero crossing, saturating
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || zero_cross_i) begin
            qcnt_ff <= 12'h000;
        end else if (qcnt_ff != 12'hfff) begin
            qcnt_ff <= qcnt_ff + 12'h001;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // ****************************************
    // Assertions
    // ****************************************
    chk_fault_stop: assert property (run && (|cause) |=>
        mode_o == 3'h3 && !shunt_connect_o) else $error("fault did not stop drivers");
    chk_fault_cause: assert property (run && (|cause) |=>
        irq_o && fault_cause_o == $past(cause)) else $error("fault record wrong");
    chk_irq_hold: assert property (irq_o && !fault_clear_i |=> irq_o)
        else $error("irq dropped without clear");
    chk_clear_idle: assert property (mode_o == 3'h3 && fault_clear_i |=>
        mode_o == 3'h1 && fault_cause_o == 4'h0 && !irq_o) else $error("clear failed");
    chk_off_hiz: assert property (mode_o == 3'h0 || mode_o == 3'h3 |->
        (coil_positive_line_drive_o | coil_return_line_drive_o) == 6'h00)
        else $error("lines driven while off");
    chk_diag_hiz: assert property (mode_o == 3'h4 |-> diag_test_enable_o &&
        (coil_positive_line_drive_o | coil_return_line_drive_o) == 6'h00)
        else $error("diagnosis lines driven");
    chk_step_take: assert property (step_load_i && step_i <= 5'h13 |=>
        current_step_o == $past(step_i)) else $error("step not applied");
    chk_boost_tx: assert property (boost_enable_o == ($past(mode_o) == 3'h2))
        else $error("boost enable outside transmit");
    chk_boost_cut: assert property (switch_overcurrent_i || supply_overvoltage_i |=>
        !boost_switch_clk_o) else $error("boost switching over limit");
    chk_sample_qtr: assert property (shunt_sample_o |-> qcnt_ff == CARRIER / 4)
        else $error("sample not a quarter period after crossing");
    chk_idle_lines: assert property (mode_o == 3'h1 |-> integrator_preset_o &&
        shunt_connect_o && coil_positive_line_mid_o == sel1h) else $error("idle lines");
    chk_spare_high: assert property (run |-> coil_return_line_drive_o == 6'h3f &&
        coil_positive_line_drive_o == 6'h3f && coil_return_line_high_o == ~sel1h)
        else $error("unselected coils not at supply");
    cov_shutdown: cover property (mode_o == 3'h3);
    cov_sample: cover property (shunt_sample_o);
    cov_diag: cover property (mode_o == 3'h4);
endmodule
bind cdf_core cdf_core_checker #(.CARRIER(CARRIER)) u_chk (.*);
`default_nettype wire

/* tb/cdf_host_model.sv */
// Host model issuing command strobes and setup loads
`timescale 1ns/10ps
`default_nettype none
module cdf_host_model (
    input wire logic core_clk_i,
    output logic [5:0] cmd_o,
    output logic [2:0] sel_o,
    output logic sel_load_o,
    output logic [4:0] step_o,
    output logic step_load_o
);
    initial begin
        cmd_o = 6'h00;
        sel_o = 3'h0;
        sel_load_o = 1'b0;
        step_o = 5'h00;
        step_load_o = 1'b0;
    end
    // One-cycle strobe: 0 wake 1 sleep 2 start 3 stop 4 diag 5 clear
    task automatic send(input int c);
        @(negedge core_clk_i);
        cmd_o[c] = 1'b1;
        @(negedge core_clk_i);
        cmd_o = 6'h00;
    endtask
    // Loads a current step or a coil index for one cycle
    task automatic load(input logic is_step, input logic [4:0] v);
        @(negedge core_clk_i);
        step_o = v;
        sel_o = v[2:0];
        step_load_o = is_step;
        sel_load_o = ~is_step;
        @(negedge core_clk_i);
        step_load_o = 1'b0;
        sel_load_o = 1'b0;
    endtask
endmodule
`default_nettype wire

/* tb/cdf_core_tb.sv */
// Self-checking bench for the coil driver fault control block
`timescale 1ns/10ps
`default_nettype none
module cdf_core_tb;
    localparam int unsigned CAR = 40; // Short carrier, quarter is 10
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [5:0] cmd, sb, sg, ol, pdrv, pact, pmid, rdrv, rhigh, fcoil;
    logic [2:0] sel, mode, csel;
    logic [4:0] stp, cstep;
    logic [3:0] fc;
    logic sel_ld, stp_ld, ot, zc, oc, ov, shc, dte, irq, ipre, ssmp, ben, bclk;
    int fails = 0;
    int checks_done = 0;
    int i;
    // Fault, crossing and limit inputs start quiet
    initial begin
        sb = 6'h00;
        sg = 6'h00;
        ol = 6'h00;
        ot = 1'b0;
        zc = 1'b0;
        oc = 1'b0;
        ov = 1'b0;
    end
    always #4 core_clk_i = ~core_clk_i;
    cdf_host_model h (.core_clk_i(core_clk_i), .cmd_o(cmd), .sel_o(sel),
        .sel_load_o(sel_ld), .step_o(stp), .step_load_o(stp_ld));
    cdf_core #(.CARRIER(CAR)) dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .wake_i(cmd[0]), .power_down_req_i(cmd[1]), .transmit_start_i(cmd[2]),
        .transmit_stop_i(cmd[3]), .diag_enter_i(cmd[4]), .fault_clear_i(cmd[5]),
        .coil_select_i(sel), .select_load_i(sel_ld), .step_i(stp), .step_load_i(stp_ld),
        .short_bat_i(sb), .short_gnd_i(sg), .open_load_i(ol), .over_temp_i(ot),
        .zero_cross_i(zc), .switch_overcurrent_i(oc), .supply_overvoltage_i(ov),
        .mode_o(mode), .coil_positive_line_drive_o(pdrv),
        .coil_positive_line_active_o(pact), .coil_positive_line_mid_o(pmid),
        .coil_return_line_drive_o(rdrv), .coil_return_line_high_o(rhigh),
        .shunt_connect_o(shc), .diag_test_enable_o(dte), .fault_cause_o(fc),
        .fault_coil_o(fcoil), .irq_o(irq), .current_step_o(cstep),
        .coil_select_o(csel), .integrator_preset_o(ipre), .shunt_sample_o(ssmp),
        .boost_enable_o(ben), .boost_switch_clk_o(bclk));
    // ****************************************
    // Tasks
    // ****************************************
    // Compares one result and counts it
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Waits for the next boost clock change, counting cycles
    task automatic span(output int n);
        logic v;
        v = bclk;
        n = 0;
        while (bclk === v && n < 2000) begin
            @(negedge core_clk_i);
            n++;
        end
    endtask
    // Raises fault cause k for one cycle, on coil c unless k is overtemperature (3)
    task automatic fault(input int k, input int c);
        @(negedge core_clk_i);
        sb[c] = (k == 0);
        sg[c] = (k == 1);
        ol[c] = (k == 2);
        ot = (k == 3);
        @(negedge core_clk_i);
        sb = 6'h00;
        sg = 6'h00;
        ol = 6'h00;
        ot = 1'b0;
    endtask
    task automatic report_and_stop();
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (2) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        chk("mode", 3'h0, mode);
        chk("drive", 6'h00, pdrv | rdrv);
        h.send(0);
        chk("mode", 3'h1, mode);
        chk("mid", 6'h01, pmid);
        chk("preset", 1'b1, ipre);
        h.load(1'b0, 5'h03);
        chk("select", 3'h3, csel);
        chk("ret high", 6'h37, rhigh);
        chk("pos drive", 6'h3f, pdrv);
        // Coil 3 is low-current, so upper steps are out of its group
        for (i = 0; i < 21; i++) begin
            h.load(1'b1, i[4:0]);
            chk("step", (i < 20) ? i : 19, cstep);
        end
        // A coil index past the sixth coil is ignored
        h.load(1'b0, 5'h06);
        chk("select", 3'h3, csel);
        chk("mid", 6'h08, pmid);
        h.send(2);
        chk("active", 6'h08, pact);
        @(negedge core_clk_i);
        chk("boost", 1'b1, ben);
        zc = 1'b1;
        @(negedge core_clk_i);
        zc = 1'b0;
        i = 0;
        while (ssmp !== 1'b1 && i < 100) begin
            @(negedge core_clk_i);
            i++;
        end
        chk("sample", CAR / 4, i);
        span(i);
        span(i);
        chk("boost half", int'(cdf_pkg::OSC_REF_HZ / cdf_pkg::BOOST_HZ / 2), i);
        for (i = 0; i < 2; i++) begin
            oc = (i == 0);
            ov = (i == 1);
            @(negedge core_clk_i);
            chk("boost clk", 1'b0, bclk);
            oc = 1'b0;
            ov = 1'b0;
        end
        for (i = 0; i < 4; i++) begin
            if (i[0]) h.send(2);
            fault(i, i + 1);
            chk("mode", 3'h3, mode);
            chk("drive", 6'h00, pdrv | rdrv);
            chk("shunt", 1'b0, shc);
            chk("cause", 4'h1 << i, fc);
            chk("coil", (i == 3) ? 6'h00 : 6'h02 << i, fcoil);
            chk("irq", 1'b1, irq);
            h.send(2);
            chk("mode", 3'h3, mode);
            h.send(5);
            chk("irq", 1'b0, irq);
            chk("mode", 3'h1, mode);
        end
        h.send(2);
        chk("mode", 3'h2, mode);
        h.send(3);
        @(negedge core_clk_i);
        chk("boost", 1'b0, ben);
        h.send(4);
        chk("mode", 3'h4, mode);
        chk("drive", 6'h00, pdrv | rdrv);
        chk("test", 1'b1, dte);
        h.send(5);
        chk("mode", 3'h1, mode);
        h.send(1);
        chk("mode", 3'h0, mode);
        report_and_stop();
    end
    // Cuts a hung run short
    initial begin
        repeat (20000) @(posedge core_clk_i);
        fails++;
        report_and_stop();
    end
endmodule
`default_nettype wire
